// File: shared/opaddr_pkg.sv
package opaddr_pkg;
	// Addressing mode of the request
	typedef enum logic [2:0] {
		MODE_IMPLIED = 3'h0,
		MODE_DIRECT = 3'h1,
		MODE_INDIRECT = 3'h2,
		MODE_INDEXED = 3'h3,
		MODE_EXTENDED = 3'h4,
		MODE_IMMEDIATE = 3'h5,
		MODE_RELATIVE = 3'h6,
		MODE_IO = 3'h7
	} mode_t;
	// Four ways of building the I/O address
	typedef enum logic [1:0] {
		IO_OPERAND_ACC = 2'h0,
		IO_FIRST_PAIR = 2'h1,
		IO_OPERAND_ZERO = 2'h2,
		IO_LOW_ZERO = 2'h3
	} io_form_t;
	// Which 16-bit field table applies (ww, xx, yy, zz)
	typedef enum logic [1:0] {
		KIND_WW = 2'h0,
		KIND_XX = 2'h1,
		KIND_YY = 2'h2,
		KIND_ZZ = 2'h3
	} pair_kind_t;
	// Register direct operand shape
	typedef enum logic [1:0] {
		DIRECT_BYTE = 2'h0,
		DIRECT_PAIR = 2'h1,
		DIRECT_HIGH = 2'h2,
		DIRECT_LOW = 2'h3
	} direct_sel_t;
	// Register chosen by the opcode itself
	typedef enum logic [2:0] {
		IMPL_ACC = 3'h0,
		IMPL_FIRST_INDEX = 3'h1,
		IMPL_SECOND_INDEX = 3'h2,
		IMPL_STACK = 3'h3,
		IMPL_FIRST_PAIR = 3'h4,
		IMPL_SECOND_PAIR = 3'h5,
		IMPL_POINTER_PAIR = 3'h6
	} implied_sel_t;
	// Register file write target
	typedef enum logic [2:0] {
		WR_FIRST_PAIR = 3'h0,
		WR_SECOND_PAIR = 3'h1,
		WR_POINTER_PAIR = 3'h2,
		WR_ACC_FLAGS = 3'h3,
		WR_FIRST_INDEX = 3'h4,
		WR_SECOND_INDEX = 3'h5,
		WR_STACK = 3'h6
	} wr_target_t;
	// 8-bit register field codes
	localparam logic [2:0] R8_FIRST_HIGH = 3'h0;
	localparam logic [2:0] R8_FIRST_LOW = 3'h1;
	localparam logic [2:0] R8_SECOND_HIGH = 3'h2;
	localparam logic [2:0] R8_SECOND_LOW = 3'h3;
	localparam logic [2:0] R8_POINTER_HIGH = 3'h4;
	localparam logic [2:0] R8_POINTER_LOW = 3'h5;
	localparam logic [2:0] R8_NONE = 3'h6;
	localparam logic [2:0] R8_ACC = 3'h7;
	// 16-bit register field codes
	localparam logic [1:0] P16_FIRST = 2'h0;
	localparam logic [1:0] P16_SECOND = 2'h1;
	localparam logic [1:0] P16_THIRD = 2'h2;
	localparam logic [1:0] P16_FOURTH = 2'h3;
	// Reset values and steps
	localparam logic [15:0] PC_RESET = 16'h0000;
	localparam logic [15:0] SP_RESET = 16'h0000;
	localparam logic [15:0] REG_RESET = 16'h0000;
	localparam logic [15:0] PC_STEP = 16'h0001;
	localparam logic [7:0] IO_HIGH_ZERO = 8'h00;
	localparam logic [7:0] BYTE_ZERO = 8'h00;
endpackage

// File: shared/reg_select_if.sv
`timescale 1ns/100ps
interface reg_select_if;
	// Register file contents
	logic [15:0] first_pair, second_pair, pointer_pair, acc_flags_pair;
	logic [15:0] first_index_reg, second_index_reg, stack_pointer;
	// Field codes from the opcode
	logic [2:0] reg8_code;
	logic [1:0] pair_code;
	opaddr_pkg::pair_kind_t pair_kind;
	// Selected values
	logic [7:0] byte_val;
	logic byte_none;
	logic [15:0] pair_val;

	modport requester(output first_pair, second_pair, pointer_pair, acc_flags_pair, first_index_reg,
		second_index_reg, stack_pointer, reg8_code, pair_code, pair_kind, input byte_val, byte_none, pair_val);
	modport selector(input first_pair, second_pair, pointer_pair, acc_flags_pair, first_index_reg,
		second_index_reg, stack_pointer, reg8_code, pair_code, pair_kind, output byte_val, byte_none, pair_val);
endinterface

// File: core/reg_select.sv
`timescale 1ns/100ps
module reg_select (
	reg_select_if.selector sel
);
	// Field decode, purely combinational
	always_comb begin
		sel.byte_none = 1'b0;
		unique case (sel.reg8_code)
			opaddr_pkg::R8_FIRST_HIGH: sel.byte_val = sel.first_pair[15:8];
			opaddr_pkg::R8_FIRST_LOW: sel.byte_val = sel.first_pair[7:0];
			opaddr_pkg::R8_SECOND_HIGH: sel.byte_val = sel.second_pair[15:8];
			opaddr_pkg::R8_SECOND_LOW: sel.byte_val = sel.second_pair[7:0];
			opaddr_pkg::R8_POINTER_HIGH: sel.byte_val = sel.pointer_pair[15:8];
			opaddr_pkg::R8_POINTER_LOW: sel.byte_val = sel.pointer_pair[7:0];
			opaddr_pkg::R8_NONE: begin
				// Code names no byte register
				sel.byte_val = opaddr_pkg::BYTE_ZERO;
				sel.byte_none = 1'b1;
			end
			opaddr_pkg::R8_ACC: sel.byte_val = sel.acc_flags_pair[15:8];
		endcase
		unique case (sel.pair_code)
			opaddr_pkg::P16_FIRST: sel.pair_val = sel.first_pair;
			opaddr_pkg::P16_SECOND: sel.pair_val = sel.second_pair;
			opaddr_pkg::P16_THIRD: begin
				// Third code depends on which table applies
				if (sel.pair_kind == opaddr_pkg::KIND_XX) begin
					sel.pair_val = sel.first_index_reg;
				end else if (sel.pair_kind == opaddr_pkg::KIND_YY) begin
					sel.pair_val = sel.second_index_reg;
				end else begin
					sel.pair_val = sel.pointer_pair;
				end
			end
			opaddr_pkg::P16_FOURTH: begin
				// Only the zz table reaches the accumulator pair
				if (sel.pair_kind == opaddr_pkg::KIND_ZZ) begin
					sel.pair_val = sel.acc_flags_pair;
				end else begin
					sel.pair_val = sel.stack_pointer;
				end
			end
		endcase
	end
endmodule

// File: core/operand_addressing_decode.sv
`timescale 1ns/100ps
module operand_addressing_decode (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic req_valid_i,
	input wire opaddr_pkg::mode_t mode_i,
	input wire logic [2:0] reg8_field_i,
	input wire logic [1:0] pair_field_i,
	input wire opaddr_pkg::pair_kind_t pair_kind_i,
	input wire opaddr_pkg::direct_sel_t direct_sel_i,
	input wire opaddr_pkg::implied_sel_t implied_sel_i,
	input wire opaddr_pkg::io_form_t io_form_i,
	input wire logic second_index_i,
	input wire logic imm_wide_i,
	input wire logic [7:0] op_low_i,
	input wire logic [7:0] op_high_i,
	input wire logic branch_take_i,
	input wire logic fetch_i,
	input wire logic wr_en_i,
	input wire opaddr_pkg::wr_target_t wr_target_i,
	input wire logic [15:0] wr_data_i,
	output logic valid_o,
	output logic [15:0] addr_o,
	output logic [15:0] operand_o,
	output logic io_request_strobe_n_o,
	output logic decode_error_o,
	output logic [15:0] program_counter_o,
	output logic [15:0] stack_pointer_o
);
	// Register file state
	logic [15:0] first_pair, second_pair, pointer_pair, acc_flags_pair;
	logic [15:0] first_index_reg, second_index_reg, stack_pointer, program_counter;
	logic [15:0] next_first_pair, next_second_pair, next_pointer_pair, next_acc_flags_pair;
	logic [15:0] next_first_index_reg, next_second_index_reg, next_stack_pointer, next_program_counter;
	// Output stage state
	logic valid, io_strobe_n, decode_error;
	logic [15:0] addr, operand;
	logic next_valid, next_io_strobe_n, next_decode_error;
	logic [15:0] next_addr, next_operand;
	// Address arithmetic
	logic [15:0] disp_ext; // Sign-extended displacement
	logic [15:0] index_base; // Chosen index register
	logic [16:0] index_sum, rel_sum, pc_sum; // One spare bit, dropped on purpose
	logic [15:0] index_addr, rel_target, pc_plus;

	// Field decoder shares the register file
	reg_select_if rs ();
	reg_select u_reg_select (
		.sel(rs.selector)
	);
	assign rs.first_pair = first_pair;
	assign rs.second_pair = second_pair;
	assign rs.pointer_pair = pointer_pair;
	assign rs.acc_flags_pair = acc_flags_pair;
	assign rs.first_index_reg = first_index_reg;
	assign rs.second_index_reg = second_index_reg;
	assign rs.stack_pointer = stack_pointer;
	assign rs.reg8_code = reg8_field_i;
	assign rs.pair_code = pair_field_i;
	// indirect uses the general pair table
	assign rs.pair_kind = (mode_i == opaddr_pkg::MODE_INDIRECT) ? opaddr_pkg::KIND_WW : pair_kind_i;

	always_comb begin
		disp_ext = {{8{op_low_i[7]}}, op_low_i};
		index_base = second_index_i ? second_index_reg : first_index_reg;
		index_sum = {1'b0, index_base} + {1'b0, disp_ext};
		rel_sum = {1'b0, program_counter} + {1'b0, disp_ext};
		pc_sum = {1'b0, program_counter} + {1'b0, opaddr_pkg::PC_STEP};
		// Carry out is discarded, no overflow flag exists
		index_addr = index_sum[15:0];
		rel_target = rel_sum[15:0];
		pc_plus = pc_sum[15:0];
	end

	// Register file next values
	always_comb begin
		next_first_pair = first_pair;
		next_second_pair = second_pair;
		next_pointer_pair = pointer_pair;
		next_acc_flags_pair = acc_flags_pair;
		next_first_index_reg = first_index_reg;
		next_second_index_reg = second_index_reg;
		next_stack_pointer = stack_pointer;
		next_program_counter = program_counter;
		if (fetch_i) begin
			next_program_counter = pc_plus;
		end
		// taken branch wins over the step
		if (req_valid_i && mode_i == opaddr_pkg::MODE_RELATIVE && branch_take_i) begin
			next_program_counter = rel_target;
		end
		// Write port from the execution unit
		if (wr_en_i) begin
			unique case (wr_target_i)
				opaddr_pkg::WR_FIRST_PAIR: next_first_pair = wr_data_i;
				opaddr_pkg::WR_SECOND_PAIR: next_second_pair = wr_data_i;
				opaddr_pkg::WR_POINTER_PAIR: next_pointer_pair = wr_data_i;
				opaddr_pkg::WR_ACC_FLAGS: next_acc_flags_pair = wr_data_i;
				opaddr_pkg::WR_FIRST_INDEX: next_first_index_reg = wr_data_i;
				opaddr_pkg::WR_SECOND_INDEX: next_second_index_reg = wr_data_i;
				opaddr_pkg::WR_STACK: next_stack_pointer = wr_data_i;
				default: next_stack_pointer = stack_pointer; // Unused code writes nothing
			endcase
		end
	end

	// Register file flops
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			first_pair <= opaddr_pkg::REG_RESET;
			second_pair <= opaddr_pkg::REG_RESET;
			pointer_pair <= opaddr_pkg::REG_RESET;
			acc_flags_pair <= opaddr_pkg::REG_RESET;
			first_index_reg <= opaddr_pkg::REG_RESET;
			second_index_reg <= opaddr_pkg::REG_RESET;
			stack_pointer <= opaddr_pkg::SP_RESET;
			program_counter <= opaddr_pkg::PC_RESET;
		end else begin
			first_pair <= next_first_pair;
			second_pair <= next_second_pair;
			pointer_pair <= next_pointer_pair;
			acc_flags_pair <= next_acc_flags_pair;
			first_index_reg <= next_first_index_reg;
			second_index_reg <= next_second_index_reg;
			stack_pointer <= next_stack_pointer;
			program_counter <= next_program_counter;
		end
	end

	// Output stage next values; address and operand hold between requests
	always_comb begin
		next_valid = req_valid_i;
		next_addr = addr;
		next_operand = operand;
		next_io_strobe_n = 1'b1;
		next_decode_error = 1'b0;
		if (req_valid_i) begin
			unique case (mode_i)
				opaddr_pkg::MODE_IMPLIED: begin
					unique case (implied_sel_i)
						opaddr_pkg::IMPL_ACC: next_operand = {opaddr_pkg::BYTE_ZERO, acc_flags_pair[15:8]};
						opaddr_pkg::IMPL_FIRST_INDEX: next_operand = first_index_reg;
						opaddr_pkg::IMPL_SECOND_INDEX: next_operand = second_index_reg;
						opaddr_pkg::IMPL_STACK: next_operand = stack_pointer;
						opaddr_pkg::IMPL_FIRST_PAIR: next_operand = first_pair;
						opaddr_pkg::IMPL_SECOND_PAIR: next_operand = second_pair;
						opaddr_pkg::IMPL_POINTER_PAIR: next_operand = pointer_pair;
						default: next_decode_error = 1'b1; // Spare code flagged
					endcase
				end
				opaddr_pkg::MODE_DIRECT: begin
					unique case (direct_sel_i)
						opaddr_pkg::DIRECT_BYTE: begin
							next_operand = {opaddr_pkg::BYTE_ZERO, rs.byte_val};
							next_decode_error = rs.byte_none;
						end
						opaddr_pkg::DIRECT_PAIR: next_operand = rs.pair_val;
						opaddr_pkg::DIRECT_HIGH: next_operand = {opaddr_pkg::BYTE_ZERO, rs.pair_val[15:8]};
						opaddr_pkg::DIRECT_LOW: next_operand = {opaddr_pkg::BYTE_ZERO, rs.pair_val[7:0]};
					endcase
				end
				opaddr_pkg::MODE_INDIRECT: begin
					// pair holds the address; stack code is refused
					next_addr = rs.pair_val;
					next_decode_error = (pair_field_i == opaddr_pkg::P16_FOURTH);
				end
				opaddr_pkg::MODE_INDEXED: next_addr = index_addr;
				opaddr_pkg::MODE_EXTENDED: next_addr = {op_high_i, op_low_i};
				opaddr_pkg::MODE_IMMEDIATE: begin
					next_operand = imm_wide_i ? {op_high_i, op_low_i} : {opaddr_pkg::BYTE_ZERO, op_low_i};
				end
				opaddr_pkg::MODE_RELATIVE: next_addr = rel_target;
				opaddr_pkg::MODE_IO: begin
					next_io_strobe_n = 1'b0;
					unique case (io_form_i)
						opaddr_pkg::IO_OPERAND_ACC: next_addr = {acc_flags_pair[15:8], op_low_i};
						// first pair halves swapped onto the bus
						opaddr_pkg::IO_FIRST_PAIR: next_addr = {first_pair[7:0], first_pair[15:8]};
						opaddr_pkg::IO_OPERAND_ZERO: next_addr = {opaddr_pkg::IO_HIGH_ZERO, op_low_i};
						opaddr_pkg::IO_LOW_ZERO: next_addr = {opaddr_pkg::IO_HIGH_ZERO, first_pair[7:0]};
					endcase
				end
			endcase
		end
	end

	// Output stage flops
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			valid <= 1'b0;
			addr <= opaddr_pkg::REG_RESET;
			operand <= opaddr_pkg::REG_RESET;
			io_strobe_n <= 1'b1;
			decode_error <= 1'b0;
		end else begin
			valid <= next_valid;
			addr <= next_addr;
			operand <= next_operand;
			io_strobe_n <= next_io_strobe_n;
			decode_error <= next_decode_error;
		end
	end

	// Ports straight from flops
	assign valid_o = valid;
	assign addr_o = addr;
	assign operand_o = operand;
	assign io_request_strobe_n_o = io_strobe_n;
	assign decode_error_o = decode_error;
	assign program_counter_o = program_counter;
	assign stack_pointer_o = stack_pointer;

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (reset_i);

	a_io_strobe_low: assert property (req_valid_i |=> (io_request_strobe_n_o == ($past(mode_i) != opaddr_pkg::MODE_IO)))
		else $error("io strobe level wrong");
	a_io_form_one: assert property ((req_valid_i && mode_i == opaddr_pkg::MODE_IO && io_form_i == opaddr_pkg::IO_OPERAND_ACC)
		|=> addr_o == {$past(acc_flags_pair[15:8]), $past(op_low_i)})
		else $error("io form one address wrong");
	a_io_form_two: assert property ((req_valid_i && mode_i == opaddr_pkg::MODE_IO && io_form_i == opaddr_pkg::IO_FIRST_PAIR)
		|=> addr_o[7:0] == $past(first_pair[15:8]) && addr_o[15:8] == $past(first_pair[7:0]))
		else $error("io form two address wrong");
	a_io_form_three: assert property ((req_valid_i && mode_i == opaddr_pkg::MODE_IO && io_form_i == opaddr_pkg::IO_OPERAND_ZERO)
		|=> addr_o == {8'h00, $past(op_low_i)})
		else $error("io form three address wrong");
	a_io_form_four: assert property ((req_valid_i && mode_i == opaddr_pkg::MODE_IO && io_form_i == opaddr_pkg::IO_LOW_ZERO)
		|=> addr_o == {8'h00, $past(first_pair[7:0])})
		else $error("io form four address wrong");
	a_indexed_sum: assert property ((req_valid_i && mode_i == opaddr_pkg::MODE_INDEXED && !second_index_i)
		|=> addr_o == 16'($past(first_index_reg) + {{8{$past(op_low_i[7])}}, $past(op_low_i)}))
		else $error("indexed address wrong");
	a_extended_addr: assert property ((req_valid_i && mode_i == opaddr_pkg::MODE_EXTENDED)
		|=> addr_o == {$past(op_high_i), $past(op_low_i)} && valid_o)
		else $error("extended address wrong");
	a_pc_advance: assert property ((fetch_i && !(req_valid_i && mode_i == opaddr_pkg::MODE_RELATIVE && branch_take_i))
		|=> program_counter_o == 16'($past(program_counter_o) + 16'h0001))
		else $error("program counter did not advance");
	a_reset_clear: assert property (@(posedge ref_clk_i) disable iff (1'b0) reset_i
		|=> program_counter_o == 16'h0000 && stack_pointer_o == 16'h0000 && io_request_strobe_n_o)
		else $error("reset did not clear counter or stack");
	a_byte_none: assert property ((req_valid_i && mode_i == opaddr_pkg::MODE_DIRECT
		&& direct_sel_i == opaddr_pkg::DIRECT_BYTE && reg8_field_i == 3'h6) |=> decode_error_o)
		else $error("byte code 110 not flagged");
endmodule

// File: verif/io_bus_model.sv
`timescale 1ns/100ps
// Far side of the address bus: latches each I/O cycle it sees
module io_bus_model (
	input wire logic ref_clk_i,
	input wire logic reset_i,
	input wire logic valid_i,
	input wire logic strobe_n_i,
	input wire logic [15:0] addr_i,
	output logic [15:0] io_addr_o,
	output logic [7:0] io_cnt_o,
	output logic strobe_err_o
);
	// Capture on the strobe; a strobe without valid is a bus fault
	// strobe low only
	always_ff @(posedge ref_clk_i) begin
		if (reset_i) begin
			io_addr_o <= 16'h0000;
			io_cnt_o <= 8'h00;
			strobe_err_o <= 1'b0;
		end else if (!strobe_n_i) begin
			io_addr_o <= addr_i;
			io_cnt_o <= io_cnt_o + 8'h01;
			// Sticky so a single stray strobe is not missed
			if (!valid_i) begin
				strobe_err_o <= 1'b1;
			end
		end
	end
endmodule

// File: verif/operand_addressing_decode_tb_top.sv
`timescale 1ns/100ps
module operand_addressing_decode_tb_top;
	// Stimulus
	logic ref_clk_i, reset_i, req_valid, six, wide, btake, fetch, wr_en;
	opaddr_pkg::mode_t mode;
	logic [2:0] r8;
	logic [1:0] pf;
	opaddr_pkg::pair_kind_t pk;
	opaddr_pkg::direct_sel_t dsel;
	opaddr_pkg::implied_sel_t isel;
	opaddr_pkg::io_form_t iof;
	opaddr_pkg::wr_target_t wr_tgt;
	logic [7:0] lo, hi;
	logic [15:0] wr_data;
	// Results
	logic valid, strobe_n, derr, strobe_err;
	logic [15:0] addr, oper, pc, sp, io_addr;
	logic [7:0] io_cnt;
	int n_fail, checks;
	// Loaded values, in write-target order; distinct so a wrong pick shows
	logic [15:0] rv [7] = '{16'hB1C2, 16'hD3E4, 16'h5A6B, 16'h7F80, 16'hFFF0, 16'h1000, 16'h2345};
	// Byte field table; code 110 has no register
	logic [7:0] bt [8] = '{8'hB1, 8'hC2, 8'hD3, 8'hE4, 8'h5A, 8'h6B, 8'h00, 8'h7F};
	// Pair tables ww, xx, yy, zz as indexes into rv
	int pt [16] = '{0, 1, 2, 6, 0, 1, 4, 6, 0, 1, 5, 6, 0, 1, 2, 3};
	operand_addressing_decode operand_addressing_decode_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i),
		.req_valid_i(req_valid), .mode_i(mode), .reg8_field_i(r8), .pair_field_i(pf), .pair_kind_i(pk),
		.direct_sel_i(dsel), .implied_sel_i(isel), .io_form_i(iof), .second_index_i(six), .imm_wide_i(wide),
		.op_low_i(lo), .op_high_i(hi), .branch_take_i(btake), .fetch_i(fetch), .wr_en_i(wr_en),
		.wr_target_i(wr_tgt), .wr_data_i(wr_data), .valid_o(valid), .addr_o(addr), .operand_o(oper),
		.io_request_strobe_n_o(strobe_n), .decode_error_o(derr), .program_counter_o(pc),
		.stack_pointer_o(sp));
	io_bus_model io_bus_model_i (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .valid_i(valid),
		.strobe_n_i(strobe_n), .addr_i(addr), .io_addr_o(io_addr), .io_cnt_o(io_cnt),
		.strobe_err_o(strobe_err));
	// Clock, 25 ns period
	initial begin
		ref_clk_i = 1'b0;
		forever #12.5 ref_clk_i = ~ref_clk_i;
	end
	task chk16(input string nm, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task chk1(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			n_fail++;
			$display("[FAIL] %s expected %b seen %b", nm, e, g);
		end
	endtask
	// Step to just after the next rising edge
	task cyc;
		@(posedge ref_clk_i);
		#1;
	endtask
	// One request; returns in the cycle where valid_o stands
	task rq(input opaddr_pkg::mode_t m);
		cyc();
		mode = m;
		req_valid = 1'b1;
		cyc();
		req_valid = 1'b0;
	endtask
	task wr(input int t, input logic [15:0] d);
		cyc();
		wr_en = 1'b1;
		wr_tgt = opaddr_pkg::wr_target_t'(t[2:0]);
		wr_data = d;
		cyc();
		wr_en = 1'b0;
	endtask
	task end_sim;
		$display("checks %0d n_fail %0d", checks, n_fail);
		if (n_fail == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	task t_load;
		chk16("pc reset", 16'h0000, pc);
		chk16("sp reset", 16'h0000, sp);
		chk1("strobe idle", 1'b1, strobe_n);
		chk1("valid idle", 1'b0, valid);
		for (int i = 0; i < 7; i++) begin
			wr(i, rv[i]);
		end
		chk16("sp write", rv[6], sp);
		// Code 7 must write nothing
		wr(7, 16'hFFFF);
		chk16("sp code7", rv[6], sp);
		$display("test load done");
	endtask
	task t_direct;
		logic [15:0] e;
		dsel = opaddr_pkg::DIRECT_BYTE;
		for (int i = 0; i < 8; i++) begin
			r8 = i[2:0];
			rq(opaddr_pkg::MODE_DIRECT);
			if (i != 6) begin
				chk16("byte", {8'h00, bt[i]}, oper);
			end
			chk1("byte err", i == 6, derr);
		end
		// Whole pair, then upper and lower byte of each table entry
		for (int s = 1; s < 4; s++) begin
			for (int k = 0; k < 16; k++) begin
				dsel = opaddr_pkg::direct_sel_t'(s[1:0]);
				pk = opaddr_pkg::pair_kind_t'(k[3:2]);
				pf = k[1:0];
				rq(opaddr_pkg::MODE_DIRECT);
				e = rv[pt[k]];
				if (s == 2) e = {8'h00, e[15:8]};
				if (s == 3) e = {8'h00, e[7:0]};
				chk16("pair", e, oper);
			end
		end
		$display("test direct done");
	endtask
	task t_mem;
		// Kind xx would give an index at code 2; indirect must ignore it
		pk = opaddr_pkg::KIND_XX;
		for (int c = 0; c < 4; c++) begin
			pf = c[1:0];
			rq(opaddr_pkg::MODE_INDIRECT);
			if (c < 3) chk16("indirect", rv[c], addr);
			chk1("indirect err", c == 3, derr);
		end
		lo = 8'h20;
		six = 1'b0;
		rq(opaddr_pkg::MODE_INDEXED);
		chk16("index wrap", 16'h0010, addr);
		lo = 8'h80;
		six = 1'b1;
		rq(opaddr_pkg::MODE_INDEXED);
		chk16("index neg", 16'h0F80, addr);
		lo = 8'h34;
		hi = 8'h12;
		rq(opaddr_pkg::MODE_EXTENDED);
		chk16("extended", 16'h1234, addr);
		chk1("no strobe", 1'b1, strobe_n);
		wide = 1'b0;
		rq(opaddr_pkg::MODE_IMMEDIATE);
		chk16("imm one", 16'h0034, oper);
		wide = 1'b1;
		rq(opaddr_pkg::MODE_IMMEDIATE);
		chk16("imm two", 16'h1234, oper);
		$display("test memory done");
	endtask
	task t_impl;
		logic [15:0] ex [7];
		ex = '{16'h007F, rv[4], rv[5], rv[6], rv[0], rv[1], rv[2]};
		for (int i = 0; i < 8; i++) begin
			isel = opaddr_pkg::implied_sel_t'(i[2:0]);
			rq(opaddr_pkg::MODE_IMPLIED);
			if (i < 7) chk16("implied", ex[i], oper);
			chk1("implied err", i == 7, derr);
		end
		$display("test implied done");
	endtask
	task t_io;
		logic [15:0] ex [4];
		ex = '{16'h7F34, 16'hC2B1, 16'h0034, 16'h00C2};
		lo = 8'h34;
		for (int f = 0; f < 4; f++) begin
			iof = opaddr_pkg::io_form_t'(f[1:0]);
			rq(opaddr_pkg::MODE_IO);
			chk1("io valid", 1'b1, valid);
			chk1("io strobe", 1'b0, strobe_n);
			cyc();
			chk1("strobe end", 1'b1, strobe_n);
			chk1("valid end", 1'b0, valid);
			chk16("io addr", ex[f], io_addr);
		end
		chk16("io count", 16'h0004, {8'h00, io_cnt});
		chk1("stray strobe", 1'b0, strobe_err);
		$display("test io done");
	endtask
	task t_pc;
		cyc();
		fetch = 1'b1;
		repeat (3) cyc();
		fetch = 1'b0;
		chk16("fetch", 16'h0003, pc);
		btake = 1'b1;
		lo = 8'hFA;
		rq(opaddr_pkg::MODE_RELATIVE);
		chk16("branch wrap", 16'hFFFD, pc);
		chk16("branch addr", 16'hFFFD, addr);
		btake = 1'b0;
		lo = 8'h10;
		rq(opaddr_pkg::MODE_RELATIVE);
		chk16("not taken", 16'hFFFD, pc);
		chk16("target addr", 16'h000D, addr);
		// Taken branch and fetch on one edge: the branch must win
		cyc();
		fetch = 1'b1;
		btake = 1'b1;
		lo = 8'h03;
		mode = opaddr_pkg::MODE_RELATIVE;
		req_valid = 1'b1;
		cyc();
		{fetch, btake, req_valid} = 3'h0;
		chk16("branch over fetch", 16'h0000, pc);
		// Reset in mid-run must clear both again
		reset_i = 1'b1;
		cyc();
		reset_i = 1'b0;
		chk16("pc rereset", 16'h0000, pc);
		chk16("sp rereset", 16'h0000, sp);
		chk1("strobe rereset", 1'b1, strobe_n);
		chk1("valid rereset", 1'b0, valid);
		// First fetch after the release steps from zero
		fetch = 1'b1;
		cyc();
		fetch = 1'b0;
		chk16("fetch after reset", 16'h0001, pc);
		$display("test counter done");
	endtask
	// Watchdog; every wait is fixed, so this only catches a stuck run
	initial begin
		#200000;
		n_fail++;
		end_sim();
	end
	initial begin
		{reset_i, req_valid, six, wide, btake, fetch, wr_en} = 7'h40;
		{r8, pf, lo, hi, wr_data} = 37'h0;
		mode = opaddr_pkg::MODE_IMPLIED;
		pk = opaddr_pkg::KIND_WW;
		dsel = opaddr_pkg::DIRECT_BYTE;
		isel = opaddr_pkg::IMPL_ACC;
		iof = opaddr_pkg::IO_OPERAND_ACC;
		wr_tgt = opaddr_pkg::WR_FIRST_PAIR;
		n_fail = 0;
		checks = 0;
		repeat (6) @(posedge ref_clk_i);
		#1;
		reset_i = 1'b0;
		t_load();
		t_direct();
		t_mem();
		t_impl();
		t_io();
		t_pc();
		end_sim();
	end
endmodule
